// ==== design/crc_clock_reset_ctrl.sv ====
// main clock, pll start-up, reset pin and wait/slow mode control
//
// Contract
// R1: pll clock delivered only after start-up delay
// R2: lock flag set when pll reaches frequency
// R3: main clock register resets zero, reserved bits
// R4: bit 1 puts cpu clock on pin; here the pin toggles once per cpu tick, half the cpu rate
// R5: bit 0 selects oscillator or divided by 32
// R6: reset pin is input and open-drain output
// R7: external reset low caught without a clock
// R8: voltage detector low drives reset pin low
// R9: supply below threshold holds static reset
// R10: watchdog underflow drives pin for least pulse
// R11: illegal opcode or prebyte also resets
// R12: slow mode clocks cpu and peripherals /32
// R13: wait entered in slow keeps divided clock
// R14: wait stops cpu, peripherals keep running
// R15: wait entry clears the global interrupt mask
// R16: wait ends on interrupt or reset, vector
// R17: slow switch only at divider boundary
// R18: reset sources merged, released after pin high
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/100ps

module crc_clock_reset_ctrl #(
    parameter int unsigned PLL_STARTUP_CYC = crc_pkg::PLL_STARTUP_CYC,
    parameter int unsigned PLL_LOCK_CYC = crc_pkg::PLL_LOCK_CYC,
    parameter int unsigned RST_PULSE_CYC = crc_pkg::RST_PULSE_CYC
) (
    input wire logic sys_clk,
    input wire logic resetn,
    // register port
    input wire logic [crc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [crc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [crc_pkg::DATA_W-1:0] reg_rdata,
    // reset pin, open drain
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe,
    // reset sources
    input wire logic lvd_below,
    input wire logic wdg_underflow,
    input wire logic illegal_opcode,
    // cpu core side
    input wire logic wakeup_halt,
    input wire logic wfi_exec,
    input wire logic irq_pending,
    output logic core_reset_n,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic cpu_wait,
    output logic int_mask_clear,
    output logic vector_req,
    output logic vector_is_reset,
    output logic pll_clk_en,
    output logic pll_lock_flag,
    // clock output pin
    output logic clkout_pin_out,
    output logic clkout_pin_oe
);

    ////////////////////////////////////////////////////////////////////////
    // elaboration checks
    localparam logic [crc_pkg::TMR_W-1:0] STARTUP_LD =
        crc_pkg::TMR_W'(PLL_STARTUP_CYC);
    localparam logic [crc_pkg::TMR_W-1:0] LOCK_LD =
        crc_pkg::TMR_W'(PLL_LOCK_CYC);
    localparam logic [crc_pkg::TMR_W-1:0] PULSE_LD =
        crc_pkg::TMR_W'(RST_PULSE_CYC);

    // counters must fit and be long enough for the checks below
    if (PLL_STARTUP_CYC < crc_pkg::MIN_DELAY_CYC ||
        PLL_STARTUP_CYC >= (1 << crc_pkg::TMR_W)) begin : g_chk_start
        $error("pll start-up count out of range");
    end
    if (PLL_LOCK_CYC < 1 ||
        PLL_LOCK_CYC >= (1 << crc_pkg::TMR_W)) begin : g_chk_lock
        $error("pll lock count out of range");
    end
    if (RST_PULSE_CYC < crc_pkg::MIN_DELAY_CYC ||
        RST_PULSE_CYC >= (1 << crc_pkg::TMR_W)) begin : g_chk_pulse
        $error("reset pulse count out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic arst_n; // power-on reset or reset pin low
    logic pin_hi; // settled level of the reset pin
    logic lvd_low; // settled supply-low indication
    logic pulse_busy; // least reset pulse still running
    logic pulse_load; // start of a pulse-type internal reset
    logic int_req; // any internal reset source active
    logic core_reset_q; // last cycle's core reset, for the rise
    logic rst_rise; // first cycle out of reset
    logic pll_start; // pll restart request
    logic startup_done; // pll start-up delay over
    logic lock_done; // pll settle delay over
    logic [crc_pkg::DIV_W-1:0] div_cnt; // slow mode prescaler
    logic div_boundary; // last count of the prescaler
    logic slow_active; // slow mode as applied to the clock
    logic tick; // one system clock worth of cpu clock
    logic slow_clock_select; // software slow mode request
    logic clock_output_enable; // software clock-out request
    crc_pkg::crc_mode_t mode; // cpu power mode
    crc_pkg::crc_mode_t next_mode;

    ////////////////////////////////////////////////////////////////////////
    // reset pin and source merging

    // the pin drops the core reset with no clock edge needed [R7]
    assign arst_n = resetn & rst_pin_in;

    crc_sync3 #(
        .RST_VAL(1'b0)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .async_in(rst_pin_in),
        .sync_out(pin_hi)
    );

    // assume the supply is low until the detector says otherwise
    crc_sync3 #(
        .RST_VAL(1'b1)
    ) u_lvd_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .async_in(lvd_below),
        .sync_out(lvd_low)
    );

    // watchdog and illegal opcode both start the least pulse [R10] [R11]
    assign pulse_load = wdg_underflow | illegal_opcode;

    crc_pulse_timer #(
        .WIDTH(crc_pkg::TMR_W)
    ) u_pulse_tmr (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .load(pulse_load),
        .load_val(PULSE_LD),
        .busy(pulse_busy),
        .done()
    );

    // one request from every internal source [R18]
    assign int_req = lvd_low | pulse_busy | pulse_load; // [R9]

    // open drain: drive low during power-on reset and while an internal source holds [R6] [R8]
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_pin_oe <= 1'b1;
        end else begin
            rst_pin_oe <= int_req; // [R10]
        end
    end

    // the driven level is always low, the pull-up makes the high
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_pin_out <= 1'b0;
        end else begin
            rst_pin_out <= 1'b0; // [R6]
        end
    end

    // release only on a clock edge, once the pin is back high and no
    // internal source or drive remains; a glitch on the pin still resets
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            core_reset_n <= 1'b0; // [R7]
        end else begin
            core_reset_n <= pin_hi & ~int_req & ~rst_pin_oe; // [R18] [R11]
        end
    end

    // edge detector for the reset release
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            core_reset_q <= 1'b0;
        end else begin
            core_reset_q <= core_reset_n;
        end
    end

    assign rst_rise = core_reset_n & ~core_reset_q;

    ////////////////////////////////////////////////////////////////////////
    // pll start-up and lock

    // restart after every reset and every wakeup from halt [R1]
    assign pll_start = rst_rise | wakeup_halt;

    crc_pulse_timer #(
        .WIDTH(crc_pkg::TMR_W)
    ) u_startup_tmr (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .load(pll_start),
        .load_val(STARTUP_LD),
        .busy(),
        .done(startup_done)
    );

    crc_pulse_timer #(
        .WIDTH(crc_pkg::TMR_W)
    ) u_lock_tmr (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .load(startup_done),
        .load_val(LOCK_LD),
        .busy(),
        .done(lock_done)
    );

    // clock gated off until the start-up delay is over [R1]
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pll_clk_en <= 1'b0;
        end else if (pll_start) begin
            pll_clk_en <= 1'b0;
        end else if (startup_done) begin
            pll_clk_en <= 1'b1;
        end
    end

    // lock flag: a set in the restart cycle is kept [R2]
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pll_lock_flag <= 1'b0;
        end else if (lock_done) begin
            pll_lock_flag <= 1'b1;
        end else if (pll_start) begin
            pll_lock_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // slow mode prescaler

    // free-running while the pll delivers, gives the /32 boundary
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            div_cnt <= '0;
        end else if (pll_clk_en) begin
            div_cnt <= div_cnt + 1'b1; // [R12]
        end
    end

    assign div_boundary = (div_cnt == crc_pkg::DIV_LAST);

    // the applied mode changes only at the boundary, no short pulse [R17]
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            slow_active <= 1'b0;
        end else if (div_boundary) begin
            slow_active <= slow_clock_select; // [R5]
        end
    end

    // one tick in 32 cycles in slow mode, every cycle otherwise [R12]
    assign tick = pll_clk_en & (~slow_active | div_boundary);

    // peripherals keep their clock in wait and slow-wait [R14] [R13]
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            periph_clk_en <= 1'b0;
        end else begin
            periph_clk_en <= tick;
        end
    end

    // cpu clock stops in wait, aligned with cpu_wait [R14]
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cpu_clk_en <= 1'b0;
        end else begin
            cpu_clk_en <= tick & core_reset_n &
                (next_mode == crc_pkg::crc_run);
        end
    end

    // clock out as a toggle per cpu tick: half the cpu rate, since a
    // fabric signal cannot carry the clock itself [R4]
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            clkout_pin_out <= 1'b0;
        end else if (clock_output_enable && tick) begin
            clkout_pin_out <= ~clkout_pin_out;
        end else if (!clock_output_enable) begin
            clkout_pin_out <= 1'b0;
        end
    end

    // pin stays free for port logic while disabled [R4]
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            clkout_pin_oe <= 1'b0;
        end else begin
            clkout_pin_oe <= clock_output_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wait mode

    // enter on the wait instruction, leave on an interrupt [R16]
    always_comb begin
        next_mode = mode;
        unique case (mode)
            crc_pkg::crc_run: begin
                if (wfi_exec) begin
                    next_mode = crc_pkg::crc_wait; // [R14]
                end
            end
            crc_pkg::crc_wait: begin
                if (irq_pending) begin
                    next_mode = crc_pkg::crc_run;
                end
            end
            default: begin
                next_mode = crc_pkg::crc_run;
            end
        endcase
        if (!core_reset_n) begin
            next_mode = crc_pkg::crc_run; // [R16]
        end
    end

    // mode register
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mode <= crc_pkg::crc_run;
        end else begin
            mode <= next_mode;
        end
    end

    // wait status flag, registered copy of the next mode
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cpu_wait <= 1'b0;
        end else begin
            cpu_wait <= (next_mode == crc_pkg::crc_wait);
        end
    end

    // one pulse on entry so every interrupt can wake the cpu [R15]
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            int_mask_clear <= 1'b0;
        end else begin
            int_mask_clear <= (mode == crc_pkg::crc_run) &&
                (next_mode == crc_pkg::crc_wait);
        end
    end

    // vector fetch request: reset vector after release, else interrupt
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            vector_req <= 1'b0;
            vector_is_reset <= 1'b0;
        end else begin
            vector_req <= rst_rise || (core_reset_n &&
                (mode == crc_pkg::crc_wait) && irq_pending); // [R16]
            vector_is_reset <= rst_rise;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register port

    // control bits cleared by every reset, reserved bits not stored [R3]
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            slow_clock_select <=
                crc_pkg::MAIN_CLK_RESET[crc_pkg::BIT_SLOW_SEL];
            clock_output_enable <=
                crc_pkg::MAIN_CLK_RESET[crc_pkg::BIT_CLKOUT_EN];
        end else if (!core_reset_n) begin
            slow_clock_select <= 1'b0; // [R5]
            clock_output_enable <= 1'b0; // [R4]
        end else if (reg_wr && reg_addr == crc_pkg::OFS_MAIN_CLK) begin
            slow_clock_select <= reg_wdata[crc_pkg::BIT_SLOW_SEL];
            clock_output_enable <= reg_wdata[crc_pkg::BIT_CLKOUT_EN];
        end
    end

    // read data stands one cycle, zero otherwise and when unmapped
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= crc_pkg::RD_ZERO;
        end else begin
            reg_rdata <= crc_pkg::RD_ZERO;
            if (reg_rd && reg_addr == crc_pkg::OFS_MAIN_CLK) begin
                reg_rdata[crc_pkg::BIT_SLOW_SEL] <= slow_clock_select;
                reg_rdata[crc_pkg::BIT_CLKOUT_EN] <= clock_output_enable;
            end else if (reg_rd && reg_addr == crc_pkg::OFS_SI_STATUS) begin
                reg_rdata[crc_pkg::BIT_LOCK] <= pll_lock_flag; // [R2]
                reg_rdata[crc_pkg::BIT_WAIT] <= cpu_wait;
                reg_rdata[crc_pkg::BIT_SLOW_ACT] <= slow_active;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_lvd_drives_pin: assert property (@(posedge sys_clk) // [R8]
        disable iff (!resetn) lvd_low |=> rst_pin_oe)
        else $error("supply low without reset pin drive");

    a_wdg_pulse_len: assert property (@(posedge sys_clk) // [R10]
        disable iff (!resetn) wdg_underflow |=> rst_pin_oe [*8])
        else $error("watchdog reset pulse too short");

    a_illegal_resets: assert property (@(posedge sys_clk) // [R11]
        disable iff (!resetn) illegal_opcode |=> !core_reset_n)
        else $error("illegal opcode did not reset the core");

    a_pin_low_holds: assert property (@(posedge sys_clk) // [R18]
        disable iff (!resetn) !pin_hi |=> !core_reset_n)
        else $error("core released while reset pin low");

    a_pll_start_delay: assert property (@(posedge sys_clk) // [R1]
        disable iff (!resetn) rst_rise |=> !pll_clk_en [*8])
        else $error("pll clock delivered before start-up delay");

    a_lock_needs_clk: assert property (@(posedge sys_clk) // [R2]
        disable iff (!resetn) $rose(pll_lock_flag) |-> pll_clk_en)
        else $error("lock flag set without pll clock");

    a_slow_tick_gap: assert property (@(posedge sys_clk) // [R12]
        disable iff (!resetn)
        (slow_active && periph_clk_en) |=> !periph_clk_en [*8])
        else $error("slow mode tick spacing too short");

    a_wait_entry: assert property (@(posedge sys_clk) // [R15]
        disable iff (!resetn)
        (mode == crc_pkg::crc_run && core_reset_n && wfi_exec)
        |=> int_mask_clear && cpu_wait)
        else $error("wait entry without mask clear");

    a_wait_stops_cpu: assert property (@(posedge sys_clk) // [R14]
        disable iff (!resetn) cpu_wait |-> !cpu_clk_en)
        else $error("cpu clocked during wait");

    a_wait_exit_irq: assert property (@(posedge sys_clk) // [R16]
        disable iff (!resetn)
        (mode == crc_pkg::crc_wait && irq_pending && core_reset_n)
        |=> vector_req && !vector_is_reset && !cpu_wait)
        else $error("interrupt did not end wait");

    a_reserved_zero: assert property (@(posedge sys_clk) // [R3]
        disable iff (!resetn)
        $past(reg_rd) |-> reg_rdata[7:3] == 5'h00)
        else $error("reserved read bits not zero");

endmodule

// ==== design/crc_pulse_timer.sv ====
// loadable down counter with busy level and end-of-count pulse
`timescale 1ns/100ps

module crc_pulse_timer #(
    parameter int unsigned WIDTH = 13
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_val,
    output logic busy,
    output logic done
);

    logic [WIDTH-1:0] cnt; // cycles still to run

    // a reload restarts the count from the top
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= '0;
        end else if (load) begin
            cnt <= load_val;
        end else if (cnt != '0) begin
            cnt <= cnt - 1'b1;
        end
    end

    // done rises with the edge that brings the count to zero
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            done <= 1'b0;
        end else begin
            done <= !load && (cnt == WIDTH'(1));
        end
    end

    assign busy = (cnt != '0);

endmodule

// ==== design/crc_sync3.sv ====
// three-stage synchroniser that passes a change once stages two and three agree
`timescale 1ns/100ps

module crc_sync3 #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic async_in,
    output logic sync_out
);

    logic s1; // metastable stage, read only by s2
    logic s2;
    logic s3;

    ////////////////////////////////////////////////////////////////////////
    // shift chain
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s1 <= RST_VAL;
            s2 <= RST_VAL;
            s3 <= RST_VAL;
        end else begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // output follows only a settled level, filters one-cycle spikes
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sync_out <= RST_VAL;
        end else if (s2 == s3) begin
            sync_out <= s3;
        end
    end

endmodule

// ==== include/crc_pkg.sv ====
// constants, register map and types of the clock and reset control block
package crc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and time base
    localparam int unsigned CLK_PERIOD_PS = 8000; // 125 mhz system clock
    localparam int unsigned TMR_W = 13; // width of the delay counters

    // pll start-up delay before the clock is delivered, least time
    localparam int unsigned PLL_STARTUP_NS = 4000;
    localparam int unsigned PLL_STARTUP_CYC =
        (PLL_STARTUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // time from clock delivery until the lock flag rises, least time
    localparam int unsigned PLL_LOCK_NS = 2000;
    localparam int unsigned PLL_LOCK_CYC =
        (PLL_LOCK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // least low time of the reset pin after an internal pulse source
    localparam int unsigned RST_PULSE_NS = 20000;
    localparam int unsigned RST_PULSE_CYC =
        (RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // least count that the in-line checks of the top module rely on
    localparam int unsigned MIN_DELAY_CYC = 9;

    ////////////////////////////////////////////////////////////////////////
    // slow mode divider
    localparam int unsigned SLOW_DIV = 32;
    localparam int unsigned DIV_W = 5;
    localparam logic [4:0] DIV_LAST = 5'h1f;

    ////////////////////////////////////////////////////////////////////////
    // register port and map
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam logic [7:0] OFS_MAIN_CLK = 8'h00; // main clock ctrl/status
    localparam logic [7:0] OFS_SI_STATUS = 8'h01; // integrity status, ro
    localparam logic [7:0] MAIN_CLK_RESET = 8'h00;
    localparam int unsigned BIT_SLOW_SEL = 0;
    localparam int unsigned BIT_CLKOUT_EN = 1;
    localparam int unsigned BIT_LOCK = 0;
    localparam int unsigned BIT_WAIT = 1;
    localparam int unsigned BIT_SLOW_ACT = 2;
    localparam logic [7:0] RD_ZERO = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // cpu power mode
    typedef enum logic [1:0] {
        crc_run  = 2'b01,
        crc_wait = 2'b10
    } crc_mode_t;

endpackage

// ==== verification/crc_reset_circuit.sv ====
// external reset circuitry and pulled-up reset wire seen by the block
`timescale 1ns/100ps

module crc_reset_circuit (
    input wire logic rst_pin_out,
    input wire logic rst_pin_oe,
    input wire logic ext_low,
    output logic rst_pin_in
);
    ////////////////////////////////////////////////////////////////////////
    // wired-and: pull-up wins unless someone pulls low
    assign rst_pin_in = !(rst_pin_oe && !rst_pin_out) && !ext_low;
endmodule

// ==== verification/tb_clock_reset_control.sv ====
// self-checking bench for the clock and reset control block
`timescale 1ns/100ps

`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    n_fail++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module tb_clock_reset_control;
    logic sys_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, ext_low = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, rv;
    logic lvd_below = 0, wdg_underflow = 0, illegal_opcode = 0;
    logic wakeup_halt = 0, wfi_exec = 0, irq_pending = 0, rst_pin_in;
    logic rst_pin_out, rst_pin_oe, core_reset_n, cpu_clk_en, periph_clk_en;
    logic cpu_wait, int_mask_clear, vector_req, vector_is_reset, pll_clk_en;
    logic pll_lock_flag, clkout_pin_out, clkout_pin_oe;
    int n_fail = 0, samples_checked = 0, k, c;

    always #4 sys_clk = ~sys_clk;

    // short counts keep the run brief
    crc_clock_reset_ctrl #(.PLL_STARTUP_CYC(12), .PLL_LOCK_CYC(4),
        .RST_PULSE_CYC(12)) u_crc_clock_reset_ctrl (.*);
    crc_reset_circuit u_crc_reset_circuit (.*);

    ////////////////////////////////////////////////////////////////////////
    task stop_test;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 0;
    endtask
    // data stand only in the cycle after the strobe
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 0;
        #1;
        `CHK("rdata", e, reg_rdata)
    endtask
    // one-cycle pulse on a source: 0 wdg, 1 opcode, 2 wfi, 3 wakeup
    task pulse(input int s);
        @(posedge sys_clk);
        wdg_underflow <= (s == 0);
        illegal_opcode <= (s == 1);
        wfi_exec <= (s == 2);
        wakeup_halt <= (s == 3);
        @(posedge sys_clk);
        {wdg_underflow, illegal_opcode, wfi_exec, wakeup_halt} <= 4'h0;
        #1;
    endtask
    // bounded wait for the core reset release, then the reset vector
    task boot;
        for (k = 0; k < 200 && core_reset_n !== 1; k++) tick(1);
        if (k == 200) begin
            n_fail++;
            stop_test;
        end
        tick(1);
        `CHK("rst vector", 2'h3, {vector_req, vector_is_reset})
    endtask
    task pll_up;
        tick(9);
        `CHK("pll early", 1'b0, pll_clk_en)
        for (k = 0; k < 20 && pll_clk_en !== 1; k++) tick(1);
        `CHK("pll late", 1'b1, pll_clk_en)
        `CHK("lock early", 1'b0, pll_lock_flag)
        tick(6);
        `CHK("lock", 1'b1, pll_lock_flag)
    endtask
    // count peripheral enables over n cycles
    task cnt_en(input int n, input int e);
        c = 0;
        for (k = 0; k < n; k++) begin
            tick(1);
            c += periph_clk_en;
        end
        `CHK("enables", e, c)
    endtask
    task leave_wait;
        @(posedge sys_clk);
        irq_pending <= 1;
        @(posedge sys_clk);
        irq_pending <= 0;
        #1;
        `CHK("irq vec", 3'h4, {vector_req, vector_is_reset, cpu_wait})
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        n_fail++;
        stop_test;
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        resetn <= 1;
        boot;
        pll_up;
        rd(8'h00, 8'h00);
        tick(1);
        `CHK("rdata idle", 8'h00, reg_rdata)
        rd(8'h05, 8'h00);
        wr(8'h00, 8'h02);
        rd(8'h00, 8'h02);
        `CHK("clkout oe", 1'b1, clkout_pin_oe)
        rv[0] = clkout_pin_out;
        tick(1);
        `CHK("clkout tgl", ~rv[0], clkout_pin_out)
        wr(8'h00, 8'h01);
        tick(1);
        `CHK("clkout off", 2'h0, {clkout_pin_oe, clkout_pin_out})
        tick(40);
        cnt_en(64, 2);
        pulse(2);
        `CHK("wait in", 2'h3, {cpu_wait, int_mask_clear})
        rd(8'h01, 8'h07);
        leave_wait;
        wr(8'h00, 8'h00);
        tick(40);
        cnt_en(8, 8);
        pulse(2);
        `CHK("wait2", 3'h7, {cpu_wait, int_mask_clear, periph_clk_en})
        `CHK("cpu held", 1'b0, cpu_clk_en)
        leave_wait;
        for (int s = 0; s < 2; s++) begin
            wr(8'h00, 8'h03);
            pulse(s);
            `CHK("int rst", 2'h2, {rst_pin_oe, core_reset_n})
            `CHK("pin level", 1'b0, rst_pin_out)
            for (k = 0; k < 100 && rst_pin_oe === 1; k++) tick(1);
            `CHK("pulse len", 1'b1, k + 1 >= 12 && k < 100)
            boot;
            rd(8'h00, 8'h00);
        end
        @(posedge sys_clk);
        lvd_below <= 1;
        tick(26);
        `CHK("lvd rst", 2'h2, {rst_pin_oe, core_reset_n})
        @(posedge sys_clk);
        lvd_below <= 0;
        boot;
        @(posedge sys_clk);
        ext_low <= 1;
        #1;
        `CHK("pin rst", 1'b0, core_reset_n)
        @(posedge sys_clk);
        ext_low <= 0;
        boot;
        pll_up;
        pulse(3);
        `CHK("pll restart", 1'b0, pll_clk_en)
        pll_up;
        stop_test;
    end
endmodule
